// File: verilog/msr_bank_pkg.sv
/*
 * Constants for the model-specific register bank: register indexes, field
 * positions, reset values, the array depth and the kernel privilege level.
 * Assumes nothing of its surroundings; compiled before the design modules.
 */
package msr_bank_pkg;
    localparam logic [31:0] IDX_L1_TEST    = 32'h0000_000E;
    localparam logic [31:0] IDX_CYCLES     = 32'h0000_0010;
    localparam logic [31:0] IDX_FEATURE    = 32'hC000_0080;
    localparam logic [31:0] IDX_CALL_TGT   = 32'hC000_0081;
    localparam logic [31:0] IDX_WRITE_HDL  = 32'hC000_0082;
    localparam logic [31:0] IDX_RANGE_CC   = 32'hC000_0085;
    localparam logic [31:0] IDX_POWER_IO   = 32'hC000_0086;
    localparam logic [31:0] IDX_OBSERVE    = 32'hC000_0087;
    localparam logic [31:0] IDX_PAGE_FLUSH = 32'hC000_0088;
    localparam logic [31:0] IDX_L2_ARRAY   = 32'hC000_0089;

    localparam int FE_CALL     = 0;
    localparam int FE_PREFETCH = 1;
    localparam int FE_SPEC_WBE = 2;
    localparam int FE_GLOB_WBE = 3;
    localparam int FE_L2_OFF   = 4;
    localparam int FE_WIDTH    = 5;
    localparam logic [4:0] FE_RESET = 5'h02;

    // Write-handling fields: limit in bits 7:1, hole enable in bit 0.
    localparam int WH_HOLE_BIT  = 0;
    localparam int WH_LIMIT_LO  = 1;
    localparam int WH_LIMIT_HI  = 7;
    // Range cacheability: range zero in the low word, range one above it;
    // bit 0 of each word marks uncacheable, bit 1 write-combining.
    localparam int RC_UC_BIT    = 0;
    localparam int RC_WC_BIT    = 1;
    localparam int RC_ONE_LO    = 32;
    // Page flush: linear page number 31:12, write back first in bit 0.
    localparam int PF_PAGE_LO   = 12;
    localparam int PF_WB_BIT    = 0;
    // L1 test control: cache disable in bit 3.
    localparam int L1_OFF_BIT   = 3;
    // Power I/O base: enable in bit 0, base address 15:4.
    localparam int PW_EN_BIT    = 0;
    localparam int PW_BASE_LO   = 4;
    localparam int PW_BASE_HI   = 15;
    // Second-level array location: tag select in bit 20 of the high word.
    localparam int L2_TAG_BIT   = 20;
    localparam int L2_ADDR_HI   = 19;
    localparam int L2_DEPTH_LOG = 4;

    localparam logic [1:0] PRIV_KERNEL = 2'h0;
endpackage

// File: verilog/l2_test_array.sv
/*
 * Second-level cache test port: a small tag array and data array of one
 * doubleword per entry, read or written through the array access register.
 * Assumes the bank drives one access strobe per instruction on mclk.
 */
module l2_test_array #(
    parameter int DEPTH_LOG = 4
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        access,
    input  wire logic        write,
    input  wire logic        tagSel,
    input  wire logic [DEPTH_LOG-1:0] location,
    input  wire logic [31:0] wrData,
    output logic      [31:0] rdData
);
    logic [31:0] tagMem  [2**DEPTH_LOG];
    logic [31:0] dataMem [2**DEPTH_LOG];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2**DEPTH_LOG; i++) begin
                tagMem[i]  <= 32'h0000_0000;
                dataMem[i] <= 32'h0000_0000;
            end
        end else if (access && write) begin
            if (tagSel) begin
                tagMem[location] <= wrData;
            end else begin
                dataMem[location] <= wrData;
            end
        end
    end

    always_comb begin
        rdData = tagSel ? tagMem[location] : dataMem[location];
    end
endmodule

// File: verilog/model_specific_register_bank.sv
/*
 * Model-specific register bank of the processor core: cycle counter,
 * feature enables, fast-call target, cache and power controls and the
 * second-level array test port, reached by register read and write ops.
 * Assumes the execution core presents one op per cycle with its index,
 * data halves and privilege level, and takes answers one cycle later.
 */
//
// Behaviour
// RL1 - Cycle counter increments every clock, no enable.
// RL2 - Counter access by index 10h only at privilege level zero.
// RL3 - Counter-read op refused outside level zero when restrict bit set.
// RL4 - Upper counter half uses high data, lower half uses low data.
// RL5 - Counter loads any written value and counts on from it.
// RL6 - Feature-enable write with reserved bit set raises protection fault.
// RL7 - Feature-enable reserved bits read as zero.
// RL8 - Feature bit 4 disables second-level cache; resets to zero.
// RL9 - Feature bits 3 and 2 are global and speculative buffer-empty disables.
// RL10 - Prefetch only while feature bit 1 set; set after reset.
// RL11 - Prefetch: read miss fetches other line of 64-byte sector.
// RL12 - Fast call and return allowed only with feature bit 0 set.
// RL13 - Call target holds return base, call base and target address.
// RL14 - Write handling holds allocate limit and 15-16 Mbyte hole enable.
// RL15 - Two ranges, each uncacheable or write-combining.
// RL16 - Page flush write invalidates one 4 Kbyte page, optional writeback.
// RL17 - Array op direction from instruction; high data picks location, tag.
// RL18 - Data array read and write use the low data register.
// RL19 - Tag array read and write use the low data register.
// RL20 - Power register holds base of a 16-byte I/O block with enable.
// RL21 - Test register at 0Eh disables first-level caches.
// RL22 - Core supplies index; data moves through low and high data.
// RL23 - Power register exists only in low-power variants.
// RL24 - Unimplemented index raises protection fault.
module model_specific_register_bank #(
    parameter bit LOW_POWER = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        registerReadOp,
    input  wire logic        registerWriteOp,
    input  wire logic        counterReadOp,
    input  wire logic        fastCallOp,
    input  wire logic        fastReturnOp,
    input  wire logic [31:0] indexRegister,
    input  wire logic [31:0] highDataIn,
    input  wire logic [31:0] lowDataIn,
    input  wire logic [1:0]  currentPrivilegeLevel,
    input  wire logic        counterReadRestrict,
    input  wire logic        readMissFill,
    input  wire logic [31:0] readMissAddr,
    output logic      [31:0] highDataOut,
    output logic      [31:0] lowDataOut,
    output logic             opDone,
    output logic             protectionFault,
    output logic             fastCallAllowed,
    output logic             secondLevelOff,
    output logic             globalBufferEmptyDisable,
    output logic             speculativeBufferEmptyDisable,
    output logic             prefetchEnable,
    output logic             prefetchReq,
    output logic      [31:0] prefetchAddr,
    output logic      [15:0] returnSelectorBase,
    output logic      [15:0] callSelectorBase,
    output logic      [31:0] callTargetAddr,
    output logic      [6:0]  writeAllocateLimit,
    output logic             writeAllocateHoleEnable,
    output logic      [63:0] rangeCacheability,
    output logic             pageFlushReq,
    output logic      [19:0] pageFlushPage,
    output logic             pageFlushWriteBack,
    output logic             firstLevelOff,
    output logic             powerIoEnable,
    output logic      [11:0] powerIoBase,
    output logic      [63:0] stateObservability
);
    // ****************************************************************
    // Storage and decode
    // ****************************************************************
    logic [63:0] cycleCounter;
    logic [4:0]  featureEnable;
    logic [63:0] fastCallTarget;
    logic [63:0] writeHandlingControl;
    logic [63:0] rangeCacheabilityControl;
    logic [63:0] powerIoReg;
    logic [63:0] observeReg;
    logic [63:0] pageFlushReg;
    logic [63:0] l1TestControl;
    logic [31:0] arrayRdData;
    logic [63:0] readValue;
    logic        kernel;
    logic        known;
    logic        feBad;
    logic        writeOk;
    logic        readOk;
    logic        counterOk;
    logic        accessFault;

    function automatic logic hit(input logic [31:0] idx,
                                 input logic [31:0] sel);
        hit = (idx == sel);
    endfunction

    assign kernel = (currentPrivilegeLevel == msr_bank_pkg::PRIV_KERNEL);

    always_comb begin
        known = hit(indexRegister, msr_bank_pkg::IDX_L1_TEST)
              | hit(indexRegister, msr_bank_pkg::IDX_CYCLES)
              | hit(indexRegister, msr_bank_pkg::IDX_FEATURE)
              | hit(indexRegister, msr_bank_pkg::IDX_CALL_TGT)
              | hit(indexRegister, msr_bank_pkg::IDX_WRITE_HDL)
              | hit(indexRegister, msr_bank_pkg::IDX_RANGE_CC)
              | hit(indexRegister, msr_bank_pkg::IDX_OBSERVE)
              | hit(indexRegister, msr_bank_pkg::IDX_PAGE_FLUSH)
              | hit(indexRegister, msr_bank_pkg::IDX_L2_ARRAY)
              | (LOW_POWER &&
                 hit(indexRegister, msr_bank_pkg::IDX_POWER_IO)); // RL23
    end

    // A feature-enable write with any of bits 63:5 set is refused.
    assign feBad = hit(indexRegister, msr_bank_pkg::IDX_FEATURE)
                 && ((highDataIn != 32'h0000_0000)
                 || (lowDataIn[31:msr_bank_pkg::FE_WIDTH] != 27'h000_0000));

    // All register read and write ops are privileged, the counter index included.
    assign accessFault = (registerReadOp || registerWriteOp)
                       && (!kernel || !known); // RL2 RL24
    assign writeOk   = registerWriteOp && kernel && known && !feBad;
    assign readOk    = registerReadOp && kernel && known;
    assign counterOk = counterReadOp && (kernel || !counterReadRestrict);

    // ****************************************************************
    // Cycle counter
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cycleCounter <= 64'h0000_0000_0000_0000;
        end else if (writeOk
                     && hit(indexRegister, msr_bank_pkg::IDX_CYCLES)) begin
            cycleCounter <= {highDataIn, lowDataIn}; // RL4 RL5 RL22
        end else begin
            cycleCounter <= cycleCounter + 64'h0000_0000_0000_0001; // RL1
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            featureEnable <= msr_bank_pkg::FE_RESET; // RL8 RL10
        end else if (writeOk
                     && hit(indexRegister, msr_bank_pkg::IDX_FEATURE)) begin
            featureEnable <= lowDataIn[msr_bank_pkg::FE_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fastCallTarget           <= 64'h0000_0000_0000_0000;
            writeHandlingControl     <= 64'h0000_0000_0000_0000;
            rangeCacheabilityControl <= 64'h0000_0000_0000_0000;
            powerIoReg               <= 64'h0000_0000_0000_0000;
            observeReg               <= 64'h0000_0000_0000_0000;
            l1TestControl            <= 64'h0000_0000_0000_0000;
        end else if (writeOk) begin
            unique case (indexRegister)
                msr_bank_pkg::IDX_CALL_TGT:
                    fastCallTarget <= {highDataIn, lowDataIn}; // RL13
                msr_bank_pkg::IDX_WRITE_HDL:
                    writeHandlingControl <= {highDataIn, lowDataIn}; // RL14
                msr_bank_pkg::IDX_RANGE_CC:
                    rangeCacheabilityControl <= {highDataIn, lowDataIn}; // RL15
                msr_bank_pkg::IDX_POWER_IO:
                    powerIoReg <= {highDataIn, lowDataIn}; // RL20
                msr_bank_pkg::IDX_OBSERVE:
                    observeReg <= {highDataIn, lowDataIn};
                msr_bank_pkg::IDX_L1_TEST:
                    l1TestControl <= {highDataIn, lowDataIn}; // RL21
                default: begin
                end
            endcase
        end
    end

    // Page flush is a command: the write stores the page and fires a pulse.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pageFlushReg <= 64'h0000_0000_0000_0000;
            pageFlushReq <= 1'b0;
        end else begin
            pageFlushReq <= writeOk
                && hit(indexRegister, msr_bank_pkg::IDX_PAGE_FLUSH); // RL16
            if (writeOk
                && hit(indexRegister, msr_bank_pkg::IDX_PAGE_FLUSH)) begin
                pageFlushReg <= {highDataIn, lowDataIn};
            end
        end
    end

    // ****************************************************************
    // Second-level array test port
    // ****************************************************************
    l2_test_array #(
        .DEPTH_LOG (msr_bank_pkg::L2_DEPTH_LOG)
    ) u_array (
        .mclk     (mclk),
        .rst      (rst),
        .access   (writeOk && hit(indexRegister, msr_bank_pkg::IDX_L2_ARRAY)),
        .write    (registerWriteOp), // RL17
        .tagSel   (highDataIn[msr_bank_pkg::L2_TAG_BIT]), // RL17
        .location (highDataIn[msr_bank_pkg::L2_DEPTH_LOG-1:0]),
        .wrData   (lowDataIn), // RL18 RL19
        .rdData   (arrayRdData)
    );

    // ****************************************************************
    // Read answers
    // ****************************************************************
    always_comb begin
        unique case (indexRegister)
            msr_bank_pkg::IDX_CYCLES: readValue = cycleCounter; // RL4
            msr_bank_pkg::IDX_FEATURE: readValue = 64'(featureEnable); // RL7
            msr_bank_pkg::IDX_CALL_TGT: readValue = fastCallTarget;
            msr_bank_pkg::IDX_WRITE_HDL: readValue = writeHandlingControl;
            msr_bank_pkg::IDX_RANGE_CC: readValue = rangeCacheabilityControl;
            msr_bank_pkg::IDX_POWER_IO: readValue = powerIoReg;
            msr_bank_pkg::IDX_OBSERVE: readValue = observeReg;
            msr_bank_pkg::IDX_PAGE_FLUSH: readValue = pageFlushReg;
            msr_bank_pkg::IDX_L1_TEST: readValue = l1TestControl;
            msr_bank_pkg::IDX_L2_ARRAY:
                readValue = {highDataIn, arrayRdData}; // RL18 RL19
            default: readValue = 64'h0000_0000_0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            highDataOut     <= 32'h0000_0000;
            lowDataOut      <= 32'h0000_0000;
            opDone          <= 1'b0;
            protectionFault <= 1'b0;
        end else begin
            opDone <= registerReadOp || registerWriteOp || counterReadOp
                   || fastCallOp || fastReturnOp;
            protectionFault <= accessFault
                || (registerWriteOp && kernel && feBad) // RL6
                || (counterReadOp && !counterOk) // RL3
                || ((fastCallOp || fastReturnOp)
                    && !featureEnable[msr_bank_pkg::FE_CALL]); // RL12
            if (counterOk) begin
                highDataOut <= cycleCounter[63:32]; // RL3 RL4
                lowDataOut  <= cycleCounter[31:0];
            end else if (readOk) begin
                {highDataOut, lowDataOut} <= readValue; // RL4 RL22
            end
        end
    end

    // ****************************************************************
    // Prefetch of the companion line
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prefetchReq  <= 1'b0;
            prefetchAddr <= 32'h0000_0000;
        end else begin
            prefetchReq <= readMissFill
                && featureEnable[msr_bank_pkg::FE_PREFETCH]; // RL10 RL11
            if (readMissFill) begin
                prefetchAddr <= {readMissAddr[31:6], ~readMissAddr[5],
                                 5'h00}; // RL11
            end
        end
    end

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    assign fastCallAllowed  = featureEnable[msr_bank_pkg::FE_CALL]; // RL12
    assign secondLevelOff   = featureEnable[msr_bank_pkg::FE_L2_OFF]; // RL8
    assign globalBufferEmptyDisable =
        featureEnable[msr_bank_pkg::FE_GLOB_WBE]; // RL9
    assign speculativeBufferEmptyDisable =
        featureEnable[msr_bank_pkg::FE_SPEC_WBE]; // RL9
    assign prefetchEnable   = featureEnable[msr_bank_pkg::FE_PREFETCH];
    assign returnSelectorBase = fastCallTarget[63:48];
    assign callSelectorBase   = fastCallTarget[47:32];
    assign callTargetAddr     = fastCallTarget[31:0];
    assign writeAllocateLimit = writeHandlingControl[
        msr_bank_pkg::WH_LIMIT_HI:msr_bank_pkg::WH_LIMIT_LO];
    assign writeAllocateHoleEnable =
        writeHandlingControl[msr_bank_pkg::WH_HOLE_BIT];
    assign rangeCacheability  = rangeCacheabilityControl;
    assign pageFlushPage      = pageFlushReg[31:msr_bank_pkg::PF_PAGE_LO];
    assign pageFlushWriteBack = pageFlushReg[msr_bank_pkg::PF_WB_BIT];
    assign firstLevelOff      = l1TestControl[msr_bank_pkg::L1_OFF_BIT];
    assign powerIoEnable      = powerIoReg[msr_bank_pkg::PW_EN_BIT];
    assign powerIoBase        = powerIoReg[
        msr_bank_pkg::PW_BASE_HI:msr_bank_pkg::PW_BASE_LO];
    assign stateObservability = observeReg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_count;
        @(posedge mclk) disable iff (rst)
        !$past(rst) && !$past(writeOk)
        |-> cycleCounter == $past(cycleCounter) + 64'h1;
    endproperty
    a_count: assert property (p_count) else $error("counter stalled"); // RL1

    property p_load;
        @(posedge mclk) disable iff (rst)
        (writeOk && indexRegister == msr_bank_pkg::IDX_CYCLES)
        |=> cycleCounter == {$past(highDataIn), $past(lowDataIn)};
    endproperty
    a_load: assert property (p_load) else $error("counter load lost"); // RL5

    property p_priv;
        @(posedge mclk) disable iff (rst)
        (registerReadOp && !kernel) |=> protectionFault;
    endproperty
    a_priv: assert property (p_priv) else $error("user access taken"); // RL2

    property p_counter_read_op;
        @(posedge mclk) disable iff (rst)
        (counterReadOp && counterReadRestrict && !kernel) |=> protectionFault;
    endproperty
    a_counter_read_op: assert property (p_counter_read_op) else $error("restricted read"); // RL3

    property p_reserved;
        @(posedge mclk) disable iff (rst)
        (registerWriteOp && kernel && feBad)
        |=> protectionFault && $stable(featureEnable);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved set"); // RL6

    property p_unknown;
        @(posedge mclk) disable iff (rst)
        (registerWriteOp && !known) |=> protectionFault;
    endproperty
    a_unknown: assert property (p_unknown) else $error("bad index"); // RL24

    property p_fastcall;
        @(posedge mclk) disable iff (rst)
        (fastCallOp && !featureEnable[msr_bank_pkg::FE_CALL])
        |=> protectionFault;
    endproperty
    a_fastcall: assert property (p_fastcall) else $error("fast call"); // RL12

    property p_prefetch;
        @(posedge mclk) disable iff (rst)
        prefetchReq |-> $past(featureEnable[msr_bank_pkg::FE_PREFETCH]);
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch"); // RL10

    property p_flush;
        @(posedge mclk) disable iff (rst)
        (writeOk && hit(indexRegister, msr_bank_pkg::IDX_PAGE_FLUSH))
        |=> pageFlushReq
            && pageFlushPage == $past(lowDataIn[31:msr_bank_pkg::PF_PAGE_LO]);
    endproperty
    a_flush: assert property (p_flush) else $error("flush lost"); // RL16
endmodule

// File: sim/core_model.sv
/*
 * Execution core model that issues one register op per call to the bank.
 * Assumes the caller paces calls on mclk; ops change at the falling edge.
 */
module core_model (
    input  wire logic        mclk,
    output logic      [4:0]  ops,
    output logic      [31:0] indexRegister,
    output logic      [31:0] highDataIn,
    output logic      [31:0] lowDataIn,
    output logic      [1:0]  currentPrivilegeLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ops = 5'h00;
        indexRegister = 32'h0000_0000;
        highDataIn = 32'h0000_0000;
        lowDataIn = 32'h0000_0000;
        currentPrivilegeLevel = 2'h0;
    end
    // Index, data halves and level are set with the op pulse and stand until the next call.
    task automatic issue(input logic [4:0] k, input logic [31:0] i,
                         input logic [31:0] h, input logic [31:0] l,
                         input logic [1:0] p);
        @(negedge mclk);
        ops <= k;
        indexRegister <= i;
        highDataIn <= h;
        lowDataIn <= l;
        currentPrivilegeLevel <= p;
        @(negedge mclk);
        ops <= 5'h00;
    endtask
endmodule

// File: sim/test_model_specific_register_bank.sv
/*
 * Self-checking bench for the register bank: register ops through the core
 * model, checks on the data halves, fault and control outputs.
 * Assumes the bank answers one cycle after each op, as handed over.
 */
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module test_model_specific_register_bank;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] RD = 5'h01, WR = 5'h02, CR = 5'h04;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic mclk, rst, counterReadRestrict, readMissFill, opDone;
    logic protectionFault, fastCallAllowed, secondLevelOff, prefetchEnable;
    logic globalBufferEmptyDisable, speculativeBufferEmptyDisable;
    logic prefetchReq, writeAllocateHoleEnable, pageFlushReq;
    logic pageFlushWriteBack, firstLevelOff, powerIoEnable;
    logic [4:0] ops;
    logic [1:0] currentPrivilegeLevel;
    logic [31:0] indexRegister, highDataIn, lowDataIn, readMissAddr;
    logic [31:0] highDataOut, lowDataOut, prefetchAddr, callTargetAddr;
    logic [15:0] returnSelectorBase, callSelectorBase;
    logic [6:0] writeAllocateLimit;
    logic [63:0] rangeCacheability, stateObservability, t0;
    logic [19:0] pageFlushPage;
    logic [11:0] powerIoBase;
    int mismatches = 0;
    int checks = 0;
    core_model core_model_i (.mclk, .ops, .indexRegister, .highDataIn,
        .lowDataIn, .currentPrivilegeLevel);
    model_specific_register_bank model_specific_register_bank_i (.mclk,
        .rst, .registerReadOp(ops[0]), .registerWriteOp(ops[1]),
        .counterReadOp(ops[2]), .fastCallOp(ops[3]), .fastReturnOp(ops[4]),
        .indexRegister, .highDataIn, .lowDataIn, .currentPrivilegeLevel,
        .counterReadRestrict, .readMissFill, .readMissAddr, .highDataOut,
        .lowDataOut, .opDone, .protectionFault, .fastCallAllowed,
        .secondLevelOff, .globalBufferEmptyDisable,
        .speculativeBufferEmptyDisable, .prefetchEnable, .prefetchReq,
        .prefetchAddr, .returnSelectorBase, .callSelectorBase,
        .callTargetAddr, .writeAllocateLimit, .writeAllocateHoleEnable,
        .rangeCacheability, .pageFlushReq, .pageFlushPage,
        .pageFlushWriteBack, .firstLevelOff, .powerIoEnable, .powerIoBase,
        .stateObservability);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic acc(input logic [4:0] k, input logic [31:0] i,
                       input logic [31:0] h, input logic [31:0] l,
                       input logic [1:0] p);
        core_model_i.issue(k, i, h, l, p);
    endtask
    task automatic miss(input logic e);
        @(negedge mclk);
        readMissFill = 1'b1;
        @(negedge mclk);
        readMissFill = 1'b0;
        `CHK("req", e, prefetchReq)
        if (e) `CHK("addr", 32'h1000_0000, prefetchAddr)
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #25000;
        mismatches++;
        wrap_up();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst = 1'b1;
        counterReadRestrict = 1'b0;
        readMissFill = 1'b0;
        readMissAddr = 32'h1000_0020;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        `CHK("pf", 1'h1, prefetchEnable)
        `CHK("l2", 1'h0, secondLevelOff)
        miss(1'b1);
        acc(WR, msr_bank_pkg::IDX_FEATURE, Z, 32'h0000_0015, 2'h0);
        `CHK("done", 1'h1, opDone)
        miss(1'b0);
        `CHK("en", 5'h15, {secondLevelOff, globalBufferEmptyDisable,
            speculativeBufferEmptyDisable, prefetchEnable,
            fastCallAllowed})
        acc(WR, msr_bank_pkg::IDX_FEATURE, 32'h0000_0001, Z, 2'h0);
        `CHK("rsv", 1'h1, protectionFault)
        acc(RD, msr_bank_pkg::IDX_FEATURE, Z, Z, 2'h0);
        `CHK("fe", 64'h0000_0000_0000_0015, {highDataOut, lowDataOut})
        for (int k = 3; k < 5; k++) begin
            acc(5'h01 << k, Z, Z, Z, 2'h3);
            `CHK("call", 1'h0, protectionFault)
        end
        acc(WR, msr_bank_pkg::IDX_CYCLES, 32'h1234_5678, 32'hFFFF_FFFE, 2'h0);
        acc(RD, msr_bank_pkg::IDX_CYCLES, Z, Z, 2'h0);
        `CHK("load", 64'h1234_5678_FFFF_FFFF, {highDataOut, lowDataOut})
        t0 = {highDataOut, lowDataOut};
        repeat (3) acc(5'h00, Z, Z, Z, 2'h0);
        counterReadRestrict = 1'b1;
        acc(CR, Z, Z, Z, 2'h0);
        `CHK("tick", t0 + 64'h8, {highDataOut, lowDataOut})
        acc(CR, Z, Z, Z, 2'h3);
        `CHK("cr3", 1'h1, protectionFault)
        counterReadRestrict = 1'b0;
        acc(CR, Z, Z, Z, 2'h3);
        `CHK("cr0", 1'h0, protectionFault)
        acc(RD, msr_bank_pkg::IDX_CYCLES, Z, Z, 2'h3);
        `CHK("cpl", 1'h1, protectionFault)
        acc(WR, msr_bank_pkg::IDX_CALL_TGT, 32'h1234_5678, 32'h9ABC_DEF0, 2'h0);
        `CHK("tgt", 64'h1234_5678_9ABC_DEF0, {returnSelectorBase,
            callSelectorBase, callTargetAddr})
        acc(RD, msr_bank_pkg::IDX_CALL_TGT, Z, Z, 2'h0);
        `CHK("rdt", 64'h1234_5678_9ABC_DEF0, {highDataOut, lowDataOut})
        acc(WR, msr_bank_pkg::IDX_WRITE_HDL, Z, 32'h0000_00FF, 2'h0);
        `CHK("wh", 8'hFF, {writeAllocateLimit, writeAllocateHoleEnable})
        acc(WR, msr_bank_pkg::IDX_RANGE_CC, 32'h0000_0002, 32'h0000_0001, 2'h0);
        `CHK("rc", 64'h0000_0002_0000_0001, rangeCacheability)
        acc(WR, msr_bank_pkg::IDX_PAGE_FLUSH, Z, 32'h0000_5001, 2'h0);
        `CHK("pg", 22'h20_000B, {pageFlushReq, pageFlushPage,
            pageFlushWriteBack})
        acc(WR, msr_bank_pkg::IDX_L1_TEST, Z, 32'h0000_0008, 2'h0);
        `CHK("l1", 1'h1, firstLevelOff)
        acc(WR, msr_bank_pkg::IDX_OBSERVE, 32'h0000_0055, 32'h0000_00AA, 2'h0);
        `CHK("obs", 64'h0000_0055_0000_00AA, stateObservability)
        acc(RD, msr_bank_pkg::IDX_OBSERVE, Z, Z, 2'h0);
        `CHK("rdo", 64'h0000_0055_0000_00AA, {highDataOut, lowDataOut})
        acc(WR, msr_bank_pkg::IDX_POWER_IO, Z, 32'h0000_1231, 2'h0);
        `CHK("pw", 13'h0247, {powerIoBase, powerIoEnable})
        acc(WR, msr_bank_pkg::IDX_L2_ARRAY, 32'h0000_0003, 32'hA5A5_0001, 2'h0);
        acc(WR, msr_bank_pkg::IDX_L2_ARRAY, 32'h0010_0003, 32'h0000_7777, 2'h0);
        acc(RD, msr_bank_pkg::IDX_L2_ARRAY, 32'h0000_0003, Z, 2'h0);
        `CHK("l2d", 32'hA5A5_0001, lowDataOut)
        acc(RD, msr_bank_pkg::IDX_L2_ARRAY, 32'h0010_0003, Z, 2'h0);
        `CHK("l2t", 32'h0000_7777, lowDataOut)
        acc(RD, 32'hC000_0083, Z, Z, 2'h0);
        `CHK("idx", 1'h1, protectionFault)
        acc(WR, msr_bank_pkg::IDX_FEATURE, Z, Z, 2'h0);
        for (int k = 3; k < 5; k++) begin
            acc(5'h01 << k, Z, Z, Z, 2'h0);
            `CHK("nocall", 1'h1, protectionFault)
        end
        acc(5'h00, Z, Z, Z, 2'h0);
        wrap_up();
    end
endmodule
